// >>> hdl/swc_regs.vh
// Functional notes
// - Sleep instruction enters power-down state
// - Watchdog zeroed on entry, keeps counting asleep
// - Sleep loads zero into watchdog and prescaler
// - Sleep clears power-down flag, sets timeout flag
// - Main oscillator off asleep, timer one oscillator runs
// - Port pins hold pre-sleep drive state
// - Watchdog reset never drives master clear low
// - Master clear wake gives full reset
// - Watchdog or interrupt wake resumes program
// - Power-down set at power-up; watchdog wake clears timeout
// - Listed peripheral sources can wake device
// - Timer one wakes only as asynchronous counter
// - Unlisted peripherals raise nothing while asleep
// - Sleep prefetches program counter plus one
// - Wake needs source enable, ignores global enable
// - After wake run next instruction, then maybe vector
// - Pending enabled flag at sleep wakes immediately
// - Watchdog cleared on every wake
`ifndef SWC_REGS_VH
`define SWC_REGS_VH
`define SWC_NSRC 9
`define SWC_SRC_TIMER_ONE 0
`define SWC_SRC_USART 1
`define SWC_SRC_ADC 2
`define SWC_SRC_IOC 3
`define SWC_SRC_EXT 4
`define SWC_SRC_CAPA 5
`define SWC_SRC_CAPB 6
`define SWC_SRC_SSP 7
`define SWC_SRC_OTHER 8
`define SWC_IRQ_VECTOR 13'h0004
`define SWC_WDT_RST 8'h00
`define SWC_PRE_RST 8'h00
`define SWC_OSC_START_NS 1000
`define SWC_OSC_START_CYC ((`SWC_OSC_START_NS + 39) / 40)
`endif

// >>> hdl/swc_wake_latch.v
`timescale 1ns/1ns
`default_nettype none
// Clockless wake catcher: any qualified request sets it asynchronously
module swc_wake_latch (
    // Control
    input wire arm,
    input wire wake_req,
    // Status
    output wire wake_hit
);
    reg hit_r;
    // Arm low forces clear; a request while armed sets with no clock
    always @(posedge wake_req or negedge arm) begin
        if (!arm) begin
            hit_r <= 1'b0;
        end else begin
            hit_r <= 1'b1;
        end
    end
    // Level already high at arm time would miss an edge, so or it in
    assign wake_hit = hit_r | (arm & wake_req);
endmodule
`default_nettype wire

// >>> hdl/swc_sleep_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "swc_regs.vh"
module swc_sleep_ctrl (
    // Clock and reset
    input wire mclk,
    input wire nrst,
    // Core side
    input wire sleep_exec,
    input wire [12:0] program_counter,
    input wire global_irq_enable,
    input wire [12:0] resume_pc,
    output reg core_run,
    output reg [12:0] fetch_addr,
    output reg fetch_valid,
    output reg vector_take,
    output reg full_reset,
    // Watchdog
    input wire wdt_enable,
    input wire wdt_timeout,
    output reg wdt_clear,
    output wire wdt_run,
    // Status flags
    output reg power_down_flag,
    output reg timeout_flag,
    // Master clear
    input wire master_clear_pin_in,
    input wire master_clear_pin_enable,
    output wire master_clear_pin_out,
    output wire master_clear_pin_oe,
    // Oscillators
    output reg osc_enable,
    input wire osc_ready,
    output wire timer_one_osc_enable,
    input wire timer_one_osc_req,
    // Wake sources
    input wire [`SWC_NSRC-1:0] irq_flag,
    input wire [`SWC_NSRC-1:0] irq_enable,
    input wire timer_one_async,
    input wire usart_sync_slave,
    input wire adc_rc_clock,
    input wire ssp_slave_mode,
    // Port hold
    input wire [7:0] port_out_live,
    input wire [7:0] port_oe_live,
    output reg [7:0] port_out,
    output reg [7:0] port_oe,
    // State
    output wire asleep
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam ST_RUN = 3'b001;
    localparam ST_SLEEP = 3'b010;
    localparam ST_WAKE = 3'b100;
    localparam integer OSC_CYC_I = `SWC_OSC_START_CYC;
    localparam [7:0] OSC_CYC = OSC_CYC_I[7:0];

    reg [2:0] state_r;
    reg [7:0] osc_cnt_r;
    reg wake_by_wdt_r;
    reg master_clear_pin_s1_r, master_clear_pin_s2_r;
    reg rdy_s1_r, rdy_s2_r;

    // ----------------------------------------
    // Wake qualification
    // ----------------------------------------
    function [`SWC_NSRC-1:0] wake_mask;
        input t1a, usy, adrc, sspm;
        begin
            wake_mask = {`SWC_NSRC{1'b1}};
            wake_mask[`SWC_SRC_TIMER_ONE] = t1a;
            wake_mask[`SWC_SRC_USART] = usy;
            wake_mask[`SWC_SRC_ADC] = adrc;
            wake_mask[`SWC_SRC_SSP] = sspm;
            wake_mask[`SWC_SRC_OTHER] = 1'b0;
        end
    endfunction

    wire [`SWC_NSRC-1:0] qual = wake_mask(timer_one_async, usart_sync_slave, adc_rc_clock, ssp_slave_mode);
    // Source enable required, global enable ignored
    wire irq_pending = |(irq_flag & irq_enable & qual);
    wire wake_req = irq_pending | (wdt_enable & wdt_timeout) | (master_clear_pin_enable & ~master_clear_pin_in);
    wire wake_hit;

    assign asleep = state_r[1];

    // Latch armed only while asleep; works with the clock stopped
    swc_wake_latch u_latch (
        .arm(asleep),
        .wake_req(wake_req),
        .wake_hit(wake_hit)
    );

    // Watchdog keeps counting during sleep
    assign wdt_run = wdt_enable;
    // Device never drives master clear, watchdog reset included
    assign master_clear_pin_out = 1'b0;
    assign master_clear_pin_oe = 1'b0;
    // Timer one oscillator independent of sleep
    assign timer_one_osc_enable = timer_one_osc_req;

    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            master_clear_pin_s1_r <= 1'b1;
            master_clear_pin_s2_r <= 1'b1;
            rdy_s1_r <= 1'b0;
            rdy_s2_r <= 1'b0;
        end else begin
            master_clear_pin_s1_r <= master_clear_pin_in;
            master_clear_pin_s2_r <= master_clear_pin_s1_r;
            rdy_s1_r <= osc_ready;
            rdy_s2_r <= rdy_s1_r;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_RUN;
            osc_cnt_r <= 8'h00;
            power_down_flag <= 1'b1;
            timeout_flag <= 1'b1;
            wake_by_wdt_r <= 1'b0;
            core_run <= 1'b1;
            osc_enable <= 1'b1;
            wdt_clear <= 1'b0;
            fetch_addr <= 13'h0000;
            fetch_valid <= 1'b0;
            vector_take <= 1'b0;
            full_reset <= 1'b0;
            port_out <= 8'h00;
            port_oe <= 8'h00;
        end else begin
            wdt_clear <= 1'b0;
            fetch_valid <= 1'b0;
            vector_take <= 1'b0;
            full_reset <= 1'b0;
            case (state_r)
                ST_RUN: begin
                    port_out <= port_out_live;
                    port_oe <= port_oe_live;
                    if (sleep_exec) begin
                        // Sleep completes even with a wake already pending
                        state_r <= ST_SLEEP;
                        core_run <= 1'b0;
                        osc_enable <= 1'b0;
                        wdt_clear <= 1'b1;
                        power_down_flag <= 1'b0;
                        timeout_flag <= 1'b1;
                        fetch_addr <= program_counter + 13'h0001;
                        fetch_valid <= 1'b1;
                    end
                end
                ST_SLEEP: begin
                    // Ports frozen; a latched wake re-enables the oscillator here
                    if (wake_hit) begin
                        osc_enable <= 1'b1;
                        osc_cnt_r <= 8'h00;
                        wake_by_wdt_r <= wdt_enable & wdt_timeout;
                        state_r <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    // Core held until the oscillator settles
                    if (rdy_s2_r && osc_cnt_r >= OSC_CYC) begin
                        wdt_clear <= 1'b1;
                        state_r <= ST_RUN;
                        if (master_clear_pin_enable && !master_clear_pin_s2_r) begin
                            full_reset <= 1'b1;
                        end else begin
                            core_run <= 1'b1;
                            if (wake_by_wdt_r) begin
                                timeout_flag <= 1'b0;
                            end
                            // Next instruction runs first, core vectors after it
                            vector_take <= global_irq_enable & ~wake_by_wdt_r;
                        end
                    end else begin
                        osc_cnt_r <= osc_cnt_r + 8'h01;
                    end
                end
                default: state_r <= ST_RUN;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> sim/swc_osc_model.sv
`timescale 1ns/1ns
`default_nettype none
module swc_osc_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Oscillator and clear pin
    input wire logic osc_enable,
    input wire logic clear_req,
    output wire logic osc_ready,
    output wire logic master_clear_pin_in
);
    // ---
    // Slow start: ready after 30 running cycles, gone once stopped
    // ---
    logic [5:0] run_r;
    // Pin idles high unless the bench asks for an external clear
    assign master_clear_pin_in = !clear_req;
    assign osc_ready = run_r == 6'h1e;
    always @(posedge mclk or negedge nrst) begin
        run_r <= !nrst ? 6'h1e : !osc_enable ? 6'h00 : run_r + {5'h00, !osc_ready};
    end
endmodule
`default_nettype wire

// >>> sim/swc_sleep_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
module swc_sleep_ctrl_properties (
    // Clock, reset and core side
    input wire mclk, input wire nrst, input wire sleep_exec, input wire [12:0] program_counter,
    input wire core_run, input wire [12:0] fetch_addr, input wire fetch_valid, input wire full_reset,
    // Status, pins and wake sources
    input wire wdt_clear, input wire power_down_flag, input wire timeout_flag, input wire osc_enable,
    input wire master_clear_pin_in, input wire master_clear_pin_enable, input wire master_clear_pin_oe,
    input wire [8:0] irq_flag, input wire [8:0] irq_enable, input wire [7:0] port_out, input wire [7:0] port_oe,
    input wire asleep
);
    // ---
    // Checks
    // ---
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire go = sleep_exec && core_run && !asleep;
    a_sleep_entry: assert property (go |=> asleep && !core_run && !osc_enable) else $error("bad entry");
    a_entry_flags: assert property (go |=> !power_down_flag && timeout_flag && wdt_clear) else $error("bad flags");
    a_prefetch_next: assert property (go |=> fetch_valid && fetch_addr == $past(program_counter) + 13'h1)
        else $error("bad prefetch");
    a_ports_frozen: assert property (asleep && $past(asleep) |-> $stable({port_out, port_oe}))
        else $error("port moved");
    a_pin_released: assert property (!master_clear_pin_oe) else $error("clear pin driven");
    a_ext_wakes: assert property (asleep && irq_flag[4] && irq_enable[4] |-> ##[0:2] osc_enable)
        else $error("no wake");
    a_wake_clears: assert property ($rose(core_run) |-> wdt_clear) else $error("watchdog kept");
    a_clear_resets: assert property (asleep && master_clear_pin_enable && !master_clear_pin_in |-> ##[1:80] full_reset)
        else $error("no full reset");
endmodule
bind swc_sleep_ctrl swc_sleep_ctrl_properties swc_sleep_ctrl_properties_inst (.*);
`default_nettype wire

// >>> sim/swc_sleep_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module swc_sleep_ctrl_tb;
    logic mclk = 1'h0, nrst = 1'h0, sleep_exec = 1'h0, global_irq_enable = 1'h0, wdt_enable = 1'h1;
    logic wdt_timeout = 1'h0, master_clear_pin_enable = 1'h1, timer_one_osc_req = 1'h1, timer_one_async = 1'h1;
    logic usart_sync_slave = 1'h1, adc_rc_clock = 1'h1, ssp_slave_mode = 1'h1, clear_req = 1'h0, vec, clr, rst;
    logic [12:0] program_counter = 13'h0, resume_pc = 13'h0;
    logic [8:0] irq_flag = 9'h0, irq_enable = 9'h0;
    logic [7:0] port_out_live = 8'h0, port_oe_live = 8'h0;
    logic [15:0] held;
    logic [31:0] rs = 32'h66d8;
    wire core_run, fetch_valid, vector_take, full_reset, wdt_clear, wdt_run, power_down_flag, timeout_flag;
    wire master_clear_pin_in, master_clear_pin_out, master_clear_pin_oe, osc_enable, osc_ready, asleep;
    wire timer_one_osc_enable;
    wire [12:0] fetch_addr;
    wire [7:0] port_out, port_oe;
    int failures = 0, checks = 0, k, n, s;
    always #20 mclk = ~mclk;
    swc_osc_model swc_osc_model_inst (.*);
    swc_sleep_ctrl swc_sleep_ctrl_inst (.*);
    // ---
    // Bench tasks
    // ---
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task go_sleep(input logic [12:0] p);
        @(negedge mclk);
        program_counter = p;
        sleep_exec = 1'h1;
        held = {port_oe_live, port_out_live};
        @(negedge mclk);
        sleep_exec = 1'h0;
        chk("entry", {3'h5, p + 13'h1}, {asleep, power_down_flag, timeout_flag, fetch_valid ? fetch_addr : 13'h0});
        chk("entry_osc", 2'h2, {wdt_clear, osc_enable});
        chk("side_pins", {timer_one_osc_req, wdt_enable, 2'h0},
            {timer_one_osc_enable, wdt_run, master_clear_pin_out, master_clear_pin_oe});
    endtask
    // Live port values keep changing so a leaky hold shows at once
    task wake(input bit w);
        vec = 1'h0;
        clr = 1'h0;
        rst = 1'h0;
        for (n = 0; n < 90 && !core_run && !rst; n++) begin
            @(negedge mclk);
            chk("port_hold", held, core_run ? held : {port_oe, port_out});
            rs = xs(rs);
            {port_oe_live, port_out_live} = rs[15:0];
            vec |= vector_take;
            clr |= wdt_clear;
            rst |= full_reset;
        end
        repeat (2) begin
            @(negedge mclk);
            vec |= vector_take;
        end
        chk("woke", w, n < 90);
        if (w && n == 90)
            report_and_stop();
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'h1;
        chk("rst", 3'h7, {power_down_flag, timeout_flag, core_run});
        for (k = 0; k < 10; k++) begin
            s = k % 9;
            global_irq_enable = k[0];
            timer_one_async = k != 0;
            usart_sync_slave = k != 1;
            go_sleep(k[12:0]);
            irq_flag = 9'h1ff;
            irq_enable = 9'h1 << s;
            wake(s < 8 && k > 1);
            if (!core_run) begin
                wdt_timeout = 1'h1;
                wake(1'h1);
                wdt_timeout = 1'h0;
                chk("wdt", 3'h1, {timeout_flag, vec, clr});
            end else begin
                chk("irq", {2'h3, global_irq_enable}, {timeout_flag, clr, vec});
            end
            irq_flag = 9'h0;
        end
        irq_flag = 9'h010;
        irq_enable = 9'h010;
        global_irq_enable = 1'h0;
        go_sleep(13'h1ffe);
        wake(1'h1);
        irq_flag = 9'h0;
        go_sleep(13'h0a5);
        clear_req = 1'h1;
        wake(1'h1);
        chk("clear_wake", 2'h2, {rst, core_run});
        nrst = 1'h0;
        clear_req = 1'h0;
        @(negedge mclk);
        nrst = 1'h1;
        chk("power_up", 2'h3, {power_down_flag, timeout_flag});
        report_and_stop();
    end
endmodule
`default_nettype wire
